//--- inc/scs_cfg.svh
// Register offsets, field positions, reset values and boot codes
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCS_OFS_CLK_MODE     8'h03
`define SCS_OFS_XTAL_CTRL    8'h0a
`define SCS_OFS_FAST_TRIM    8'h0b
`define SCS_OFS_STATUS       8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCS_XTAL_EN_BIT      7
`define SCS_XTAL_DRV_HI      6
`define SCS_XTAL_DRV_LO      5
`define SCS_FAST_EN_BIT      4
`define SCS_SLOW_EN_BIT      2
`define SCS_MODE_SEL_HI      7
`define SCS_MODE_SEL_LO      5
`define SCS_MODE_SUB_BIT     3

// ----------------------------------------
// Reset and boot values
// ----------------------------------------
`define SCS_XTAL_RST         8'h00
`define SCS_TRIM_RST         8'h80
`define SCS_BOOT_FAST_MODE   8'h5c
`define SCS_BOOT_SLOW_MODE   8'hf4

// ----------------------------------------
// Calibration option mode values
// ----------------------------------------
`define SCS_CAL_DIV2         8'h34
`define SCS_CAL_DIV4         8'h14
`define SCS_CAL_DIV8         8'h3c
`define SCS_CAL_DIV16        8'h1c
`define SCS_CAL_DIV32        8'h7c
`define SCS_CAL_SLOW         8'he4

// ----------------------------------------
// Calibration option select codes
// ----------------------------------------
`define SCS_OPT_DIV2         3'h0
`define SCS_OPT_DIV4         3'h1
`define SCS_OPT_DIV8         3'h2
`define SCS_OPT_DIV16        3'h3
`define SCS_OPT_DIV32        3'h4
`define SCS_OPT_SLOW         3'h5

`endif

//--- inc/scs_pkg.sv
// Types shared by the clock source control modules
package scs_pkg;

    // ----------------------------------------
    // System clock candidates
    // ----------------------------------------
    typedef enum logic [2:0] {
        SRC_SLOW,
        SRC_XTAL,
        SRC_DIV2,
        SRC_DIV4,
        SRC_DIV8,
        SRC_DIV16,
        SRC_DIV32,
        SRC_DIV64
    } scs_src_t;

    typedef enum logic [1:0] {
        ST_BOOT,
        ST_CAL,
        ST_RUN
    } scs_state_t;

endpackage

//--- inc/scs_clk_if.sv
// Carrier between controller, fast RC divider and glitch-free switch
`timescale 1ns/100ps
interface scs_clk_if;
    logic             fast_lvl;
    logic [5:0]       div_lvl;
    logic [7:0]       cand;
    scs_pkg::scs_src_t sel_req;
    scs_pkg::scs_src_t cur_sel;
    logic             sys_clk;
    logic             sys_tick;

    modport divider  (input fast_lvl, output div_lvl);
    modport switcher (input cand, sel_req, output cur_sel, sys_clk, sys_tick);
    modport ctrl     (output fast_lvl, cand, sel_req,
                      input div_lvl, cur_sel, sys_clk, sys_tick);
endinterface // scs_clk_if

//--- hdl/scs_fast_div.sv
// Divider chain on the fast RC level, /2 to /64
`timescale 1ns/100ps
module scs_fast_div #(
    parameter int WIDTH = 6
) (
    input  wire logic   i_core_clk,
    input  wire logic   i_rst,
    scs_clk_if.divider  div_if
);
    logic             fast_q_r;
    logic [WIDTH-1:0] cnt_r;

    // ----------------------------------------
    // Count rising edges of the fast RC
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fast_q_r <= 1'b0;
            cnt_r    <= '0;
        end else begin
            fast_q_r <= div_if.fast_lvl;
            if (div_if.fast_lvl && !fast_q_r) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign div_if.div_lvl = cnt_r;
endmodule // scs_fast_div

//--- hdl/scs_clk_switch.sv
// Glitch-free system clock selection
`timescale 1ns/100ps
module scs_clk_switch (
    input  wire logic   i_core_clk,
    input  wire logic   i_rst,
    scs_clk_if.switcher sw_if
);
    scs_pkg::scs_src_t cur_r;
    logic              out_r;
    logic              tick_r;

    // ----------------------------------------
    // Move only while old and new are both low
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cur_r <= scs_pkg::SRC_SLOW;
        end else if (sw_if.sel_req != cur_r && !sw_if.cand[cur_r]
                     && !sw_if.cand[sw_if.sel_req]) begin
            cur_r <= sw_if.sel_req; // [RULE_16] [RULE_19]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            out_r  <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            out_r  <= sw_if.cand[cur_r];
            tick_r <= sw_if.cand[cur_r] && !out_r;
        end
    end

    assign sw_if.cur_sel  = cur_r;
    assign sw_if.sys_clk  = out_r;
    assign sw_if.sys_tick = tick_r;
endmodule // scs_clk_switch

//--- hdl/scs_clock_ctrl.sv
// System clock source control: registers, boot calibration, selection
//
// Behaviour
// RULE_01 - Three oscillators each have own enable bit
// RULE_02 - Both RC oscillators enabled at hardware boot
// RULE_03 - Trim register calibrates fast RC to target
// RULE_04 - Mode 34h selects fast RC divided by 2
// RULE_05 - Mode 14h selects fast RC divided by 4
// RULE_06 - Mode 3Ch selects fast RC divided by 8
// RULE_07 - Mode 1Ch selects fast RC divided by 16
// RULE_08 - Mode 7Ch selects fast RC divided by 32
// RULE_09 - Mode E4h selects slow RC, fast off
// RULE_10 - Calibrated boot: watchdog off, slow on, pin input
// RULE_11 - No calibration: mode untouched, slow or /64
// RULE_12 - No calibration: watchdog on, slow on, pin input
// RULE_13 - Crystal bits 6:5 select drive strength
// RULE_14 - Crystal control register at 0x0a
// RULE_15 - Software picks clock by writing mode register
// RULE_16 - Clock switches right after mode write
// RULE_17 - Software disables old oscillator only later
// RULE_18 - Software enables and settles oscillator first
// RULE_19 - Switching never truncates clock phases
`timescale 1ns/100ps
`include "scs_cfg.svh"
module scs_clock_ctrl #(
    parameter int DIV_W = 6
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_xtal_lvl,
    input  wire logic       i_fast_rc_lvl,
    input  wire logic       i_slow_rc_lvl,
    input  wire logic [2:0] i_cal_sel,
    input  wire logic       i_boot_fast,
    input  wire logic [7:0] i_factory_trim,
    output logic            o_xtal_en,
    output logic      [1:0] o_xtal_drive,
    output logic            o_fast_rc_en,
    output logic            o_slow_rc_en,
    output logic      [7:0] o_fast_trim,
    output logic            o_sys_clk,
    output logic            o_sys_clk_tick,
    output logic      [2:0] o_sys_src,
    output logic            o_wdt_en,
    output logic            o_port_a_pin5_in,
    output logic            o_boot_done
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic scs_pkg::scs_src_t mode_src(input logic [7:0] m);
        logic [3:0] code;
        code = {m[`SCS_MODE_SEL_HI:`SCS_MODE_SEL_LO], m[`SCS_MODE_SUB_BIT]};
        unique case (code)
            4'h2:    mode_src = scs_pkg::SRC_DIV2;  // [RULE_04]
            4'h0:    mode_src = scs_pkg::SRC_DIV4;  // [RULE_05]
            4'h3:    mode_src = scs_pkg::SRC_DIV8;  // [RULE_06]
            4'h1:    mode_src = scs_pkg::SRC_DIV16; // [RULE_07]
            4'h7:    mode_src = scs_pkg::SRC_DIV32; // [RULE_08]
            4'h5:    mode_src = scs_pkg::SRC_DIV64; // [RULE_11]
            4'he:    mode_src = scs_pkg::SRC_SLOW;  // [RULE_09]
            4'ha:    mode_src = scs_pkg::SRC_XTAL;
            default: mode_src = scs_pkg::SRC_SLOW;
        endcase
    endfunction

    function automatic logic [7:0] cal_mode(input logic [2:0] opt);
        unique case (opt)
            `SCS_OPT_DIV2:  cal_mode = `SCS_CAL_DIV2;
            `SCS_OPT_DIV4:  cal_mode = `SCS_CAL_DIV4;
            `SCS_OPT_DIV8:  cal_mode = `SCS_CAL_DIV8;
            `SCS_OPT_DIV16: cal_mode = `SCS_CAL_DIV16;
            `SCS_OPT_DIV32: cal_mode = `SCS_CAL_DIV32;
            `SCS_OPT_SLOW:  cal_mode = `SCS_CAL_SLOW;
            default:        cal_mode = 8'h00;
        endcase
    endfunction

    function automatic logic cal_on(input logic [2:0] opt);
        cal_on = (opt <= `SCS_OPT_SLOW);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    scs_pkg::scs_state_t state_r;
    logic [7:0]          mode_r;
    logic [7:0]          xtal_r;
    logic [7:0]          trim_r;
    logic [7:0]          rdata_r;
    logic                wdt_r;
    logic                pin5_in_r;
    logic [2:0]          opt_r;

    logic                wr_mode;
    logic                wr_xtal;
    logic                wr_trim;
    logic                fast_on;
    logic                slow_on;
    logic                xtal_on;

    scs_clk_if           clk_if ();

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    assign wr_mode = i_wr && (i_addr == `SCS_OFS_CLK_MODE);
    assign wr_xtal = i_wr && (i_addr == `SCS_OFS_XTAL_CTRL); // [RULE_14]
    assign wr_trim = i_wr && (i_addr == `SCS_OFS_FAST_TRIM);

    // ----------------------------------------
    // Boot sequence
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_r <= scs_pkg::ST_BOOT;
            opt_r   <= i_cal_sel;
        end else begin
            unique case (state_r)
                scs_pkg::ST_BOOT: state_r <= scs_pkg::ST_CAL;
                scs_pkg::ST_CAL:  state_r <= scs_pkg::ST_RUN;
                scs_pkg::ST_RUN:  state_r <= scs_pkg::ST_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Clock mode register
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            // Both RC oscillators on at boot [RULE_02]
            mode_r <= i_boot_fast ? `SCS_BOOT_FAST_MODE
                                  : `SCS_BOOT_SLOW_MODE; // [RULE_11]
        end else if (state_r == scs_pkg::ST_CAL) begin
            if (cal_on(opt_r)) begin
                mode_r <= cal_mode(opt_r); // [RULE_04] [RULE_09]
            end
        end else if (wr_mode) begin
            mode_r <= i_wdata; // [RULE_16]
        end
    end

    // ----------------------------------------
    // Crystal control register
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            xtal_r <= `SCS_XTAL_RST;
        end else if (wr_xtal) begin
            xtal_r <= {i_wdata[`SCS_XTAL_EN_BIT:`SCS_XTAL_DRV_LO], 5'h00}; // [RULE_13]
        end
    end

    // ----------------------------------------
    // Fast RC trim register
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            trim_r <= `SCS_TRIM_RST;
        end else if (state_r == scs_pkg::ST_CAL) begin
            if (cal_on(opt_r)) begin
                trim_r <= i_factory_trim; // [RULE_03]
            end
        end else if (wr_trim) begin
            trim_r <= i_wdata; // [RULE_03]
        end
    end

    // ----------------------------------------
    // Watchdog and pin state after boot
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wdt_r     <= 1'b1;
            pin5_in_r <= 1'b1;
        end else if (state_r == scs_pkg::ST_CAL) begin
            wdt_r     <= !cal_on(opt_r); // [RULE_10] [RULE_12]
            pin5_in_r <= 1'b1;           // [RULE_10] [RULE_12]
        end
    end

    // ----------------------------------------
    // Oscillator enables
    // ----------------------------------------
    assign xtal_on = xtal_r[`SCS_XTAL_EN_BIT]; // [RULE_01]
    assign fast_on = mode_r[`SCS_FAST_EN_BIT]; // [RULE_01]
    assign slow_on = mode_r[`SCS_SLOW_EN_BIT]; // [RULE_01]

    // ----------------------------------------
    // Candidate clocks
    // ----------------------------------------
    assign clk_if.fast_lvl = i_fast_rc_lvl && fast_on;
    assign clk_if.cand = {clk_if.div_lvl,
                          i_xtal_lvl && xtal_on,
                          i_slow_rc_lvl && slow_on};
    assign clk_if.sel_req = mode_src(mode_r); // [RULE_16]

    scs_fast_div #(
        .WIDTH (DIV_W)
    ) u_div (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .div_if     (clk_if)
    );

    scs_clk_switch u_sw (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .sw_if      (clk_if)
    );

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                `SCS_OFS_CLK_MODE:  rdata_r <= mode_r;
                `SCS_OFS_XTAL_CTRL: rdata_r <= xtal_r;
                `SCS_OFS_FAST_TRIM: rdata_r <= trim_r;
                `SCS_OFS_STATUS:    rdata_r <= {3'h0, wdt_r,
                                                state_r == scs_pkg::ST_RUN,
                                                clk_if.cur_sel};
                default:            rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rdata          = rdata_r;
    assign o_xtal_en        = xtal_on;
    assign o_xtal_drive     = xtal_r[`SCS_XTAL_DRV_HI:`SCS_XTAL_DRV_LO]; // [RULE_13]
    assign o_fast_rc_en     = fast_on;
    assign o_slow_rc_en     = slow_on;
    assign o_fast_trim      = trim_r;
    assign o_sys_clk        = clk_if.sys_clk;
    assign o_sys_clk_tick   = clk_if.sys_tick;
    assign o_sys_src        = clk_if.cur_sel;
    assign o_wdt_en         = wdt_r;
    assign o_port_a_pin5_in = pin5_in_r;
    assign o_boot_done      = (state_r == scs_pkg::ST_RUN);

endmodule // scs_clock_ctrl

//--- verification/scs_clock_ctrl_monitor.sv
// Port-level checks for the clock source control block
`timescale 1ns/100ps
`include "scs_cfg.svh"
module scs_clock_ctrl_monitor (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] o_rdata,
    input  wire logic       o_xtal_en,
    input  wire logic [1:0] o_xtal_drive,
    input  wire logic       o_fast_rc_en,
    input  wire logic       o_slow_rc_en,
    input  wire logic [7:0] o_fast_trim,
    input  wire logic       o_sys_clk,
    input  wire logic       o_sys_clk_tick,
    input  wire logic       o_boot_done
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    property p_fast_en;
        i_wr && i_addr == `SCS_OFS_CLK_MODE && o_boot_done |=> o_fast_rc_en == $past(i_wdata[4]);
    endproperty
    a_fast_en: assert property (p_fast_en) else $error("fast enable mismatch");
    property p_slow_en;
        i_wr && i_addr == `SCS_OFS_CLK_MODE && o_boot_done |=> o_slow_rc_en == $past(i_wdata[2]);
    endproperty
    a_slow_en: assert property (p_slow_en) else $error("slow enable mismatch");
    property p_xtal;
        i_wr && i_addr == 8'h0a |=> {o_xtal_en, o_xtal_drive} == $past(i_wdata[7:5]);
    endproperty
    a_xtal: assert property (p_xtal) else $error("crystal control mismatch");
    property p_trim;
        i_wr && i_addr == `SCS_OFS_FAST_TRIM && o_boot_done |=> o_fast_trim == $past(i_wdata);
    endproperty
    a_trim: assert property (p_trim) else $error("trim mismatch");
    property p_rd_xtal;
        i_rd && i_addr == 8'h0a |=> o_rdata == {o_xtal_en, o_xtal_drive, 5'h00};
    endproperty
    a_rd_xtal: assert property (p_rd_xtal) else $error("crystal read mismatch");
    property p_rd_idle;
        !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
    property p_tick;
        o_sys_clk_tick == $rose(o_sys_clk);
    endproperty
    a_tick: assert property (p_tick) else $error("tick not on clock rise");
    property p_boot;
        $fell(i_rst) |-> ##[1:4] o_boot_done;
    endproperty
    a_boot: assert property (p_boot) else $error("boot not finished");
    property p_rst_osc;
        $fell(i_rst) |-> o_fast_rc_en && o_slow_rc_en;
    endproperty
    a_rst_osc: assert property (p_rst_osc) else $error("oscillators off at boot");
endmodule // scs_clock_ctrl_monitor

bind scs_clock_ctrl scs_clock_ctrl_monitor u_mon (.*);

//--- verification/tb_scs_clock_ctrl.sv
// Self-checking testbench for the clock source control block
`timescale 1ns/100ps
`include "scs_cfg.svh"
module tb_scs_clock_ctrl;
    logic       i_core_clk, i_rst, i_wr, i_rd, i_boot_fast;
    logic       i_xtal_lvl, i_fast_rc_lvl, i_slow_rc_lvl;
    logic       o_xtal_en, o_fast_rc_en, o_slow_rc_en, o_sys_clk, o_sys_clk_tick;
    logic       o_wdt_en, o_port_a_pin5_in, o_boot_done;
    logic [1:0] o_xtal_drive;
    logic [2:0] i_cal_sel, o_sys_src;
    logic [7:0] i_addr, i_wdata, i_factory_trim, o_rdata, o_fast_trim, lvl_cnt;
    int         failures, total_checks;
    logic [7:0] mode_tab [6] = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'he4};
    logic [2:0] src_tab [6]  = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
    int         per_tab [6]  = '{4, 8, 16, 32, 64, 16};

    scs_clock_ctrl dut (
        .i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_xtal_lvl, .i_fast_rc_lvl, .i_slow_rc_lvl, .i_cal_sel, .i_boot_fast,
        .i_factory_trim, .o_xtal_en, .o_xtal_drive, .o_fast_rc_en, .o_slow_rc_en,
        .o_fast_trim, .o_sys_clk, .o_sys_clk_tick, .o_sys_src, .o_wdt_en,
        .o_port_a_pin5_in, .o_boot_done
    );

    // ----------------------------------------
    // Clock and oscillator levels
    // ----------------------------------------
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        lvl_cnt <= lvl_cnt + 8'h01;
    end
    assign i_fast_rc_lvl = lvl_cnt[0];
    assign i_xtal_lvl    = lvl_cnt[1];
    assign i_slow_rc_lvl = lvl_cnt[3];

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask
    task automatic src_per(input logic [2:0] src, input int per);
        int n;
        n = 0;
        while (o_sys_src !== src && n < 400) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        chk({5'h00, o_sys_src}, {5'h00, src});
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge i_core_clk);
                #1;
                n++;
            end while (o_sys_clk_tick !== 1'b1 && n < 300);
        end
        chk(n[7:0], per[7:0]);
        if (n >= 300) begin
            failures++;
            wrap_up();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic boot_case(input logic [2:0] opt, input logic fast);
        logic       cal;
        logic [2:0] src;
        int         per;
        cal = opt < 3'h6;
        src = cal ? src_tab[opt] : {fast, fast, fast};
        per = cal ? per_tab[opt] : (fast ? 128 : 16);
        i_cal_sel   <= opt;
        i_boot_fast <= fast;
        i_rst       <= 1'b1;
        repeat (10) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        #1;
        chk({7'h00, o_wdt_en}, {7'h00, !cal});
        chk({6'h00, o_slow_rc_en, o_port_a_pin5_in}, 8'h03);
        rdc(`SCS_OFS_CLK_MODE, cal ? mode_tab[opt] : (fast ? 8'h5c : 8'hf4));
        rdc(`SCS_OFS_FAST_TRIM, cal ? i_factory_trim : 8'h80);
        src_per(src, per);
        rdc(`SCS_OFS_STATUS, {3'h0, !cal, 1'b1, src});
    endtask
    task automatic mode_walk;
        for (int k = 0; k < 5; k++) begin
            wr(`SCS_OFS_CLK_MODE, mode_tab[k]);
            chk({6'h00, o_fast_rc_en, o_slow_rc_en}, 8'h03);
            src_per(src_tab[k], per_tab[k]);
        end
        wr(`SCS_OFS_CLK_MODE, 8'hf4);
        src_per(3'h0, 16);
        wr(`SCS_OFS_CLK_MODE, 8'he4);
        chk({6'h00, o_fast_rc_en, o_slow_rc_en}, 8'h01);
        src_per(3'h0, 16);
        wr(`SCS_OFS_FAST_TRIM, 8'hc3);
        rdc(`SCS_OFS_FAST_TRIM, 8'hc3);
    endtask
    task automatic xtal_case;
        for (int k = 1; k < 4; k++) begin
            wr(8'h0a, {1'b1, k[1:0], 5'h1f});
            chk({5'h00, o_xtal_en, o_xtal_drive}, {5'h01, k[1:0]});
            rdc(8'h0a, {1'b1, k[1:0], 5'h00});
        end
        wr(`SCS_OFS_CLK_MODE, 8'hb4);
        src_per(3'h1, 4);
        wr(`SCS_OFS_CLK_MODE, 8'hf4);
        src_per(3'h0, 16);
        wr(8'h0a, 8'h00);
        chk({7'h00, o_xtal_en}, 8'h00);
        wr(8'h55, 8'hff);
        rdc(8'h55, 8'h00);
    endtask

    initial begin
        lvl_cnt        = 8'h00;
        i_rst          = 1'b1;
        i_wr           = 1'b0;
        i_rd           = 1'b0;
        i_addr         = 8'h00;
        i_wdata        = 8'h00;
        i_cal_sel      = 3'h7;
        i_boot_fast    = 1'b0;
        i_factory_trim = 8'h5a;
        failures       = 0;
        total_checks   = 0;
        for (int k = 0; k < 8; k++) begin
            boot_case(k[2:0], k[0]);
        end
        mode_walk();
        xtal_case();
        wrap_up();
    end
endmodule // tb_scs_clock_ctrl
